// >>> core/adc_control_registers.sv
// converter control: apb registers, conversion sequencer, pin and reference decode
//
// Functional notes
// - channel field 000..100 picks input 0..4
// - done loads result, clears go, sets flag
// - power-on low keeps converter fully off
// - align 1: right justify, high bits zero
// - align 0: left justify, low bits zero
// - clock-halve doubles system clock division
// - config bits 5 and 4 read zero
// - port code decodes analog/digital pin roles
// - reference codes use input 3 and 2
// - two bit periods before next acquisition
// - result ten bits, comparator decides bits 9..1, bit 0 stays one (512 steps)
// - clearing go aborts, result kept
// - clock select 11 uses internal rc
`timescale 1ns/10ps
`default_nettype none
module adc_control_registers (
   input  wire logic                   clk,
   input  wire logic                   rstn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic                        pready,
   output logic [31:0]                 prdata,
   output logic                        pslverr,
   input  wire logic                   rc_tick_in,
   input  wire logic                   comparator_in,
   output logic                        conv_enable,
   output logic                        sample_en,
   output logic [2:0]                  channel_mux,
   output logic [9:0]                  dac_code,
   output adc_ctrl_pkg::pin_cfg_t      pin_cfg,
   output logic                        conv_done_flag
);
   import adc_ctrl_pkg::*;

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   logic [1:0]  conv_clk_select;
   logic [2:0]  channel_select;
   logic        go;
   logic        conv_power_on;
   logic        result_align_select;
   logic        clk_halve_select;
   logic [3:0]  port_cfg_code;
   logic [7:0]  result_high;
   logic [7:0]  result_low;
   conv_state_t state;
   logic [3:0]  bit_cnt;
   logic [9:0]  sar;
   logic        tick;
   logic        cmp_s1;
   logic        cmp_s2;
   logic        wr_en;
   logic        rd_en;
   logic        wr_go_clear;
   logic        finish;
   logic [7:0]  ctrl0_val;
   logic [7:0]  ctrl1_val;
   logic [15:0] next_result;
   clk_cfg_t    clk_cfg;
   pin_cfg_t    next_pin_cfg;

   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign clk_cfg = '{halve: clk_halve_select, sel: conv_clk_select};
   assign finish = (state == st_convert) && tick && (bit_cnt == 4'(result_bits));
   assign wr_go_clear = wr_en && (paddr == addr_conv_ctrl_reg0) && !pwdata[pos_go];

   assign ctrl0_val = {conv_clk_select, channel_select, go, 1'b0, conv_power_on};
   assign ctrl1_val = {result_align_select, clk_halve_select, 2'b00, port_cfg_code};

   adc_tick_gen u_tick (
      .clk        (clk),
      .rstn       (rstn),
      .run        (state == st_convert || state == st_gap),
      .cfg        (clk_cfg),
      .rc_tick_in (rc_tick_in),
      .tick       (tick)
   );

   // -------------------------------------------------------------
   // comparator synchroniser
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cmp_s1 <= 1'b0;
         cmp_s2 <= 1'b0;
      end else begin
         cmp_s1 <= comparator_in;
         cmp_s2 <= cmp_s1;
      end
   end

   // -------------------------------------------------------------
   // control register 0 fields
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         conv_clk_select <= reset_ctrl0[pos_conv_clk_select +: 2];
         channel_select  <= reset_ctrl0[pos_channel_select +: 3];
         conv_power_on   <= reset_ctrl0[pos_conv_power_on];
      end else if (wr_en && paddr == addr_conv_ctrl_reg0) begin
         conv_clk_select <= pwdata[pos_conv_clk_select +: 2];
         channel_select  <= pwdata[pos_channel_select +: 3];
         conv_power_on   <= pwdata[pos_conv_power_on];
      end
   end

   // go flag: set only if powered, done clears it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         go <= reset_ctrl0[pos_go];
      end else if (finish || !conv_power_on) begin
         go <= 1'b0;
      end else if (wr_en && paddr == addr_conv_ctrl_reg0) begin
         // a start needs power already on and an idle sequencer
         go <= pwdata[pos_go] && pwdata[pos_conv_power_on]
               && (state == st_idle || go);
      end
   end

   // -------------------------------------------------------------
   // control register 1
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         result_align_select <= reset_ctrl1[pos_result_align_select];
         clk_halve_select    <= reset_ctrl1[pos_clk_halve_select];
         port_cfg_code       <= reset_ctrl1[pos_port_cfg_code +: 4];
      end else if (wr_en && paddr == addr_conv_ctrl_reg1) begin
         result_align_select <= pwdata[pos_result_align_select];
         clk_halve_select    <= pwdata[pos_clk_halve_select];
         port_cfg_code       <= pwdata[pos_port_cfg_code +: 4];
      end
   end

   // -------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state   <= st_off;
         bit_cnt <= 4'd0;
         sar     <= 10'h000;
      end else if (!conv_power_on) begin
         state   <= st_off;
         bit_cnt <= 4'd0;
      end else begin
         unique case (state)
            st_off: begin
               state <= st_idle;
            end
            st_idle: begin
               if (go) begin
                  state   <= st_convert;
                  bit_cnt <= 4'd0;
                  sar     <= 10'h200;
               end
            end
            st_convert: begin
               if (wr_go_clear) begin
                  state   <= st_gap;
                  bit_cnt <= 4'd0;
               end else if (tick) begin
                  // slot 0 is the sample slot, slots 1..9 decide one bit each, slot 10 ends
                  if (bit_cnt == 4'(result_bits)) begin
                     state   <= st_gap;
                     bit_cnt <= 4'd0;
                  end else begin
                     bit_cnt <= bit_cnt + 4'd1;
                     if (bit_cnt != 4'd0) begin
                        sar[4'(result_bits) - bit_cnt] <= cmp_s2;
                        if (bit_cnt != 4'(result_bits))
                           sar[4'(result_bits - 1) - bit_cnt] <= 1'b1;
                     end
                  end
               end
            end
            st_gap: begin
               if (tick) begin
                  if (bit_cnt == 4'(gap_bit_periods - 1)) begin
                     state   <= st_idle;
                     bit_cnt <= 4'd0;
                  end else begin
                     bit_cnt <= bit_cnt + 4'd1;
                  end
               end
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // result registers; writable as plain storage
   // -------------------------------------------------------------
   always_comb begin
      if (result_align_select)
         next_result = {6'h00, sar};
      else
         next_result = {sar, 6'h00};
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         result_high <= reset_result;
         result_low  <= reset_result;
      end else if (finish && !wr_go_clear) begin
         result_high <= next_result[15:8];
         result_low  <= next_result[7:0];
      end else if (wr_en && paddr == addr_result_high) begin
         result_high <= pwdata[7:0];
      end else if (wr_en && paddr == addr_result_low) begin
         result_low  <= pwdata[7:0];
      end
   end

   // done flag: hardware set wins over software clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         conv_done_flag <= 1'b0;
      end else if (finish && !wr_go_clear) begin
         conv_done_flag <= 1'b1;
      end else if (wr_en && paddr == addr_irq_status && pwdata[pos_conv_done_flag]) begin
         conv_done_flag <= 1'b0;  // write one to clear
      end
   end

   // -------------------------------------------------------------
   // pin roles and analog outputs
   // -------------------------------------------------------------
   always_comb begin
      unique case (port_cfg_code)
         4'b0000, 4'b0010, 4'b1001: next_pin_cfg = '{5'b11111, 1'b0, 1'b0};
         4'b0001, 4'b0011, 4'b1010: next_pin_cfg = '{5'b10111, 1'b1, 1'b0};
         4'b0100:                   next_pin_cfg = '{5'b01011, 1'b0, 1'b0};
         4'b0101:                   next_pin_cfg = '{5'b00011, 1'b1, 1'b0};
         4'b0110, 4'b0111:          next_pin_cfg = '{5'b00000, 1'b0, 1'b0};
         4'b1000, 4'b1011, 4'b1100: next_pin_cfg = '{5'b10011, 1'b1, 1'b1};
         4'b1101:                   next_pin_cfg = '{5'b00011, 1'b1, 1'b1};
         4'b1110:                   next_pin_cfg = '{5'b00001, 1'b0, 1'b0};
         default:                   next_pin_cfg = '{5'b00001, 1'b1, 1'b1};
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_cfg     <= '{5'b11111, 1'b0, 1'b0};
         conv_enable <= 1'b0;
         sample_en   <= 1'b0;
         channel_mux <= 3'd0;
         dac_code    <= 10'h000;
      end else begin
         pin_cfg     <= next_pin_cfg;
         conv_enable <= conv_power_on;
         // holding capacitor is disconnected during conversion and gap
         sample_en   <= (state == st_idle);
         // codes above 100 are unmapped; park on input 0
         channel_mux <= (channel_select > 3'(max_channel)) ? 3'd0 : channel_select;
         dac_code    <= sar;
      end
   end

   // -------------------------------------------------------------
   // apb slave: zero wait states, unmapped reads zero with error
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel && !penable) begin
            unique case (paddr)
               addr_conv_ctrl_reg0: prdata <= {24'h0, ctrl0_val & ctrl0_rd_mask};
               addr_conv_ctrl_reg1: prdata <= {24'h0, ctrl1_val & ctrl1_rd_mask};
               addr_result_high:    prdata <= {24'h0, result_high};
               addr_result_low:     prdata <= {24'h0, result_low};
               addr_irq_status:     prdata <= {31'h0, conv_done_flag};
               default:             pslverr <= 1'b1;
            endcase
         end
      end
   end

endmodule : adc_control_registers
`default_nettype wire

// >>> core/adc_ctrl_pkg.sv
// package: register map, field layout and timing constants of the converter control block
package adc_ctrl_pkg;

   // -------------------------------------------------------------
   // register map (byte addresses; offsets 0x1f/0x9f are indices)
   // -------------------------------------------------------------
   localparam logic [7:0]  idx_conv_ctrl_reg0 = 8'h1f;
   localparam logic [7:0]  idx_conv_ctrl_reg1 = 8'h9f;
   localparam logic [11:0] addr_conv_ctrl_reg0 = 12'h07c;
   localparam logic [11:0] addr_conv_ctrl_reg1 = 12'h27c;
   localparam logic [11:0] addr_result_high    = 12'h300;
   localparam logic [11:0] addr_result_low     = 12'h304;
   localparam logic [11:0] addr_irq_status     = 12'h308;

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int pos_conv_power_on       = 0;
   localparam int pos_go                  = 2;
   localparam int pos_channel_select      = 3;
   localparam int pos_conv_clk_select     = 6;
   localparam int pos_port_cfg_code       = 0;
   localparam int pos_clk_halve_select    = 6;
   localparam int pos_result_align_select = 7;
   localparam int pos_conv_done_flag      = 0;

   // -------------------------------------------------------------
   // reset values and masks
   // -------------------------------------------------------------
   localparam logic [7:0] reset_ctrl0     = 8'h00;
   localparam logic [7:0] reset_ctrl1     = 8'h00;
   localparam logic [7:0] ctrl0_rd_mask   = 8'hfd;
   localparam logic [7:0] ctrl1_rd_mask   = 8'hcf;
   localparam logic [7:0] reset_result    = 8'h00;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int result_bits       = 10;
   localparam int conv_bit_periods  = 11;  // one sample slot, nine bit decisions, one closing slot
   localparam int gap_bit_periods   = 2;
   localparam int max_channel       = 4;

   typedef enum logic [3:0] {
      st_idle    = 4'b0001,
      st_convert = 4'b0010,
      st_gap     = 4'b0100,
      st_off     = 4'b1000
   } conv_state_t;

   typedef struct packed {
      logic       halve;
      logic [1:0] sel;
   } clk_cfg_t;

   typedef struct packed {
      logic [4:0] analog_en;
      logic       vref_pos_ext;
      logic       vref_neg_ext;
   } pin_cfg_t;

endpackage : adc_ctrl_pkg

// >>> core/adc_tick_gen.sv
// conversion bit clock divider: system clock prescaler or internal rc source
`timescale 1ns/10ps
`default_nettype none
module adc_tick_gen (
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic                  run,
   input  wire adc_ctrl_pkg::clk_cfg_t cfg,
   input  wire logic                  rc_tick_in,
   output logic                       tick
);
   import adc_ctrl_pkg::*;

   logic [5:0] cnt;
   logic [5:0] limit;
   logic       rc_s1;
   logic       rc_s2;
   logic       rc_s3;

   // -------------------------------------------------------------
   // divide: 2,8,32 tosc or 4,16,64 with the extra halving
   // -------------------------------------------------------------
   always_comb begin
      unique case (cfg.sel)
         2'b00:   limit = cfg.halve ? 6'd3  : 6'd1;
         2'b01:   limit = cfg.halve ? 6'd15 : 6'd7;
         default: limit = cfg.halve ? 6'd63 : 6'd31;
      endcase
   end

   // rc source comes from another oscillator, so synchronise it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rc_s1 <= 1'b0;
         rc_s2 <= 1'b0;
         rc_s3 <= 1'b0;
      end else begin
         rc_s1 <= rc_tick_in;
         rc_s2 <= rc_s1;
         rc_s3 <= rc_s2;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt  <= 6'd0;
         tick <= 1'b0;
      end else if (!run) begin
         cnt  <= 6'd0;
         tick <= 1'b0;
      end else if (cfg.sel == 2'b11) begin
         tick <= rc_s2 & ~rc_s3;
      end else if (cnt >= limit) begin
         cnt  <= 6'd0;
         tick <= 1'b1;
      end else begin
         cnt  <= cnt + 6'd1;
         tick <= 1'b0;
      end
   end

endmodule : adc_tick_gen
`default_nettype wire

// >>> dv/adc_control_registers_bench.sv
// testbench: register, conversion and pin decode scenarios of the converter control block
`timescale 1ns/10ps
`default_nettype none
module adc_control_registers_bench import adc_ctrl_pkg::*;;
   logic        clk, rstn, psel, penable, pwrite, pready, pslverr, er;
   logic        rc_tick_in, comparator_in, conv_enable, sample_en, conv_done_flag;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  channel_mux;
   logic [9:0]  dac_code;
   pin_cfg_t    pin_cfg;
   int          n_errors, n_tests, cyc, d0, d1;
   localparam logic [3:0] pc_code [10] = '{4'h0, 4'h2, 4'h9, 4'h6, 4'h7, 4'he, 4'h8, 4'hb, 4'hf, 4'ha};
   localparam logic [6:0] pc_exp [10] = '{7'h7c, 7'h7c, 7'h7c, 7'h00, 7'h00, 7'h04, 7'h03, 7'h03,
                                          7'h03, 7'h02};
   localparam logic [6:0] pc_mask [10] = '{7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h03, 7'h03,
                                           7'h03, 7'h03};
   adc_control_registers adc_control_registers_i (
      .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .rc_tick_in(rc_tick_in), .comparator_in(comparator_in), .conv_enable(conv_enable),
      .sample_en(sample_en), .channel_mux(channel_mux), .dac_code(dac_code), .pin_cfg(pin_cfg),
      .conv_done_flag(conv_done_flag));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task test_done;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 16) begin
         n++;
         @(posedge clk);
      end
      chk(n < 16, 1'b1, "apb answer");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task conv(output int c);
      apb(1'b1, addr_conv_ctrl_reg0, 32'h05);
      c = 0;
      while (conv_done_flag !== 1'b1 && c < 400) begin
         @(posedge clk);
         c++;
      end
      chk(conv_done_flag, 1'b1, "done flag");
   endtask : conv
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      apb(1'b0, addr_conv_ctrl_reg0, 32'h0);
      chk(rd, {24'h0, reset_ctrl0}, "ctrl0 reset");
      apb(1'b0, addr_conv_ctrl_reg1, 32'h0);
      chk(rd, {24'h0, reset_ctrl1}, "ctrl1 reset");
      chk({25'h0, pin_cfg}, 32'h7c, "pins after reset");
      chk(conv_enable, 1'b0, "off after reset");
   endtask : t_reset
   task t_regs;
      apb(1'b1, addr_conv_ctrl_reg1, 32'hff);
      apb(1'b0, addr_conv_ctrl_reg1, 32'h0);
      chk(rd, 32'hcf, "ctrl1 readback");
      apb(1'b1, addr_conv_ctrl_reg0, 32'hfa);
      apb(1'b0, addr_conv_ctrl_reg0, 32'h0);
      chk(rd, 32'hf8, "ctrl0 readback");
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, addr_conv_ctrl_reg0, c << 3);
         @(posedge clk);
         chk(channel_mux, (c <= max_channel) ? c : 0, "channel route");
      end
      apb(1'b0, 12'h100, 32'h0);
      chk({er, rd}, {1'b1, 32'h0}, "unmapped access");
   endtask : t_regs
   task t_pcfg;
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, addr_conv_ctrl_reg1, {28'h0, pc_code[i]});
         @(posedge clk);
         chk({25'h0, pin_cfg & pc_mask[i]}, {25'h0, pc_exp[i]}, "pin decode");
      end
   endtask : t_pcfg
   task t_convert(input logic align, input logic [31:0] ehi, input logic [31:0] elo);
      apb(1'b1, addr_conv_ctrl_reg1, {24'h0, align, 7'h0});
      comparator_in <= 1'b1; // pin driven as an input
      apb(1'b1, addr_conv_ctrl_reg0, 32'h01);
      repeat (10) @(posedge clk); // acquisition before go
      conv(d0);
      apb(1'b0, addr_conv_ctrl_reg0, 32'h0);
      chk(rd, 32'h01, "go cleared");
      chk(dac_code, 32'h3ff, "trial word all ones");
      apb(1'b0, addr_result_high, 32'h0);
      chk(rd, ehi, "result high");
      apb(1'b0, addr_result_low, 32'h0);
      chk(rd, elo, "result low");
      apb(1'b1, addr_irq_status, 32'h1);
      chk(conv_done_flag, 1'b0, "flag cleared");
   endtask : t_convert
   task t_abort;
      comparator_in <= 1'b0;
      apb(1'b1, addr_conv_ctrl_reg0, 32'h05);
      repeat (6) @(posedge clk);
      apb(1'b1, addr_conv_ctrl_reg0, 32'h01);
      repeat (60) @(posedge clk);
      chk(conv_done_flag, 1'b0, "done after abort");
      apb(1'b0, addr_result_high, 32'h0);
      chk(rd, 32'hff, "result kept");
   endtask : t_abort
   task t_off;
      apb(1'b1, addr_conv_ctrl_reg0, 32'h00);
      apb(1'b1, addr_conv_ctrl_reg0, 32'h04);
      repeat (60) @(posedge clk);
      chk({conv_done_flag, conv_enable, sample_en}, 3'h0, "converter off");
      apb(1'b0, addr_conv_ctrl_reg0, 32'h0);
      chk(rd, 32'h00, "go ignored when off");
   endtask : t_off
   task t_halve;
      apb(1'b1, addr_conv_ctrl_reg1, 32'h00);
      apb(1'b1, addr_conv_ctrl_reg0, 32'h01);
      repeat (10) @(posedge clk);
      conv(d0);
      apb(1'b1, addr_irq_status, 32'h1);
      repeat (10) @(posedge clk);
      apb(1'b1, addr_conv_ctrl_reg1, 32'h40);
      conv(d1);
      apb(1'b1, addr_conv_ctrl_reg0, 32'h05);
      apb(1'b0, addr_conv_ctrl_reg0, 32'h0);
      chk(rd, 32'h01, "go refused in gap");
      // eleven periods, two extra clocks each; slack for divider phase
      chk(d1 - d0 >= 16 && d1 - d0 <= 28, 1'b1, "halved clock length");
      repeat (20) @(posedge clk);
      apb(1'b1, addr_irq_status, 32'h1);
   endtask : t_halve
   task t_rc;
      apb(1'b1, addr_conv_ctrl_reg0, 32'hc1);
      repeat (10) @(posedge clk);
      apb(1'b1, addr_conv_ctrl_reg0, 32'hc5);
      repeat (100) @(posedge clk);
      chk(conv_done_flag, 1'b0, "rc source idle");
      for (int i = 0; i < 200 && conv_done_flag !== 1'b1; i++) begin
         repeat (3) @(posedge clk);
         rc_tick_in <= ~rc_tick_in;
      end
      chk(conv_done_flag, 1'b1, "rc conversion");
      apb(1'b1, addr_conv_ctrl_reg0, 32'h00);
   endtask : t_rc
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         test_done();
      end
   end
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      rc_tick_in = 1'b0;
      comparator_in = 1'b0;
      n_errors = 0;
      n_tests = 0;
      cyc = 0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_regs();
      t_pcfg();
      t_convert(1'b1, 32'h03, 32'hff);
      t_convert(1'b0, 32'hff, 32'hc0);
      t_abort();
      t_off();
      t_halve();
      t_rc();
      test_done();
   end
endmodule : adc_control_registers_bench
`default_nettype wire

// >>> dv/adc_control_registers_props.sv
// checker: port-level properties of the converter control block
`timescale 1ns/10ps
`default_nettype none
module adc_control_registers_props import adc_ctrl_pkg::*; (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        rc_tick_in,
   input wire logic        comparator_in,
   input wire logic        conv_enable,
   input wire logic        sample_en,
   input wire logic [2:0]  channel_mux,
   input wire logic [9:0]  dac_code,
   input wire pin_cfg_t    pin_cfg,
   input wire logic        conv_done_flag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   logic       wr0;
   logic       wr1;
   logic [2:0] last_ch;
   assign wr0 = psel && penable && pwrite && (paddr == addr_conv_ctrl_reg0);
   assign wr1 = psel && penable && pwrite && (paddr == addr_conv_ctrl_reg1);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) last_ch <= 3'h0;
      else if (wr0) last_ch <= pwdata[5:3];
   end
   // ----------------------------------------
   // properties; ranges allow one output register stage
   // ----------------------------------------
   AST_ZERO_WAIT: assert property (psel && penable |-> pready)
      else $error("access cycle without pready");
   AST_ERR_QUIET: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bus error without pready or with data");
   AST_CHAN_ROUTE: assert property (wr0 && pwdata[5:3] <= 3'h4 |=> ##[0:1] channel_mux == last_ch)
      else $error("channel not routed");
   AST_CHAN_SPARE: assert property (wr0 && pwdata[5:3] > 3'h4 |=> ##[0:1] channel_mux == 3'h0)
      else $error("spare channel code routed");
   AST_OFF_IDLE: assert property (!conv_enable [*2] |-> !sample_en)
      else $error("sampling while powered off");
   AST_OFF_NODONE: assert property (!conv_enable [*2] |-> !$rose(conv_done_flag))
      else $error("done while powered off");
   AST_CFG1_READ: assert property (psel && penable && !pwrite && paddr == addr_conv_ctrl_reg1
      |-> prdata[5:4] == 2'h0 && prdata[31:8] == 24'h0)
      else $error("config read shows unused bits");
   AST_GAP: assert property ($rose(conv_done_flag) |-> !sample_en [*4])
      else $error("acquisition before the gap ended");
   AST_ABORT: assert property (wr0 && !pwdata[2] |-> ##2 !$rose(conv_done_flag) [*8])
      else $error("done after abort");
   AST_NOGO_OFF: assert property (wr0 && pwdata[2] && !pwdata[0] |=> !$rose(conv_done_flag) [*8])
      else $error("go taken while powered off");
   AST_PCFG_ONE: assert property (wr1 && pwdata[3:0] == 4'he |-> ##[1:2] pin_cfg.analog_en == 5'h01)
      else $error("single analog pin code wrong");
   AST_PCFG_DIG: assert property (wr1 && pwdata[3:1] == 3'h3 |-> ##[1:2] pin_cfg.analog_en == 5'h00)
      else $error("all digital code wrong");
   AST_PCFG_REF: assert property (wr1 && pwdata[3:0] == 4'h8
      |-> ##[1:2] pin_cfg.vref_pos_ext && pin_cfg.vref_neg_ext)
      else $error("reference pins not selected");
endmodule : adc_control_registers_props
bind adc_control_registers adc_control_registers_props adc_control_registers_props_i (
   .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .rc_tick_in(rc_tick_in), .comparator_in(comparator_in), .conv_enable(conv_enable),
   .sample_en(sample_en), .channel_mux(channel_mux), .dac_code(dac_code), .pin_cfg(pin_cfg),
   .conv_done_flag(conv_done_flag));
`default_nettype wire
